// ### include/isb_consts.svh
/*
 Constants of the rate-smoothing buffer: register offsets, field
 positions, reset values and fill-count codes.
 Assumes it is included by bare name into the design and the bench.
*/
`ifndef ISB_CONSTS_SVH
`define ISB_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISB_OFF_CTRL 5'h00
`define ISB_OFF_STAT 5'h04
`define ISB_OFF_DIN 5'h08
`define ISB_OFF_SVC 5'h0C
`define ISB_OFF_DOUT 5'h10
`define ISB_OFF_OPRES 5'h14
`define ISB_OFF_MODIFY 5'h18

// ----------------------------------------------------------------
// Control fields and codes
// ----------------------------------------------------------------
`define ISB_CTRL_WIDTH 1:0
`define ISB_CTRL_DIR 2
`define ISB_CTRL_OFF 4:3
`define ISB_W_ONE 2'h0
`define ISB_W_TWO 2'h1
`define ISB_CTRL_RST 5'h00

// ----------------------------------------------------------------
// Fill count, inverted form, and pointer reset
// ----------------------------------------------------------------
`define ISB_FILL_EMPTY 4'hF
`define ISB_FILL_FULL 4'h7
`define ISB_PTR_RST 3'h0

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define ISB_RESP_OKAY 2'h0
`define ISB_RESP_SLVERR 2'h2

`endif

// ### include/isb_pkg.sv
/*
 Types of the rate-smoothing buffer: bus carriers, phase enum and the
 single state record of the design.
 Assumes isb_consts.svh is on the include path.
*/
package isb_pkg;

    // ----------------------------------------------------------------
    // AXI4-Lite carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [4:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [4:0] araddr;
        logic rready;
    } isb_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } isb_axi_rsp_t;

    // Output-service phases
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ONE,
        PH_TWO,
        PH_FOUR
    } isb_phase_t;

    // Lanes packed A..D from the top: A at [35:27], presence at bit 8 of each
    typedef struct packed {
        logic [4:0] ctrl;
        logic [1:0] start_off;
        logic [1:0] boff;
        logic [2:0] write_pointer;
        logic [2:0] read_pointer;
        logic [2:0] location_select;
        logic [3:0] fill_count;
        logic [3:0] presence_generator;
        logic [3:0] saved_pres;
        logic memory_request_latch;
        logic input_loaded_flag;
        logic [31:0] mem_asm;
        logic [35:0] in_stage;
        logic [17:0] mid_stage;
        logic mid_valid;
        logic [35:0] out_stage;
        isb_phase_t phase;
        logic [7:0][35:0] lanes;
        logic aw_got;
        logic [4:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } isb_state_t;

endpackage : isb_pkg

// ### design/isb_buffer.sv
/*
 Rate-smoothing data buffer of a channel I/O processor: four byte lanes
 of eight locations, pointers, fill count, input, intermediate and
 output stages, output-service phase sequence, AXI4-Lite registers.
 Assumes one clock, synchronous active-low reset, inputs synchronous.
*/
// Functional notes
// - four lanes, eight nine-bit locations, presence bit
// - lane use follows device interface width
// - output commutation at input, alignment at output
// - input transfers decommutate at buffer output
// - location select takes write or read pointer
// - location select decodes as plain binary
// - write pointer increments, clears on chaining
// - read pointer advances, clears on chaining
// - inverted fill count, 1111 empty, 0111 full
// - presence modify steps read pointer back
// - input stage loads memory or device data
// - two-lane intermediate stage for narrow output
// - one-lane output: lane A takes first present input byte
// - clear written presence bits, lane A first
// - phase one builds presence, requests, counts
// - phase two saves generator into saved latch
// - phase four loads input stage, sets flag
// - byte offset realignment both directions
// - saved latch holds presence across update
`timescale 1ns/1ns
`include "isb_consts.svh"

module isb_buffer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire isb_pkg::isb_axi_req_t s_req,
    output isb_pkg::isb_axi_rsp_t s_rsp
);
    import isb_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Rotate toward later lanes by n whole lanes
    function automatic logic [35:0] rotr(input logic [35:0] x, input logic [1:0] n);
        case (n)
            2'd1: return {x[8:0], x[35:9]};
            2'd2: return {x[17:0], x[35:18]};
            2'd3: return {x[26:0], x[35:27]};
            default: return x;
        endcase
    endfunction : rotr

    function automatic logic [3:0] pres_of(input logic [35:0] x);
        return {x[35], x[26], x[17], x[8]};
    endfunction : pres_of

    // Lanes from offset up to offset+count-1, clipped at lane D
    function automatic logic [3:0] gen_pres(input logic [1:0] off, input logic [2:0] cnt);
        logic [3:0] g;
        g = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (3'(i) >= {1'b0, off} && 4'(i) < {2'b00, off} + {1'b0, cnt})
                g[3 - i] = 1'b1;
        end
        return g;
    endfunction : gen_pres

    isb_state_t s_r;
    isb_state_t s_n;
    logic do_wr;
    logic do_rd;
    logic do_mod;
    logic [1:0] width;
    logic out_dir;
    logic narrow;
    logic [35:0] lane_mask;
    logic [35:0] rd_word;
    logic [2:0] mod_loc;
    logic chain;

    assign width = s_r.ctrl[`ISB_CTRL_WIDTH];
    assign out_dir = s_r.ctrl[`ISB_CTRL_DIR];
    assign narrow = (width == `ISB_W_ONE) || (width == `ISB_W_TWO);
    // Unused lanes are masked so narrow interfaces never see stale bytes
    assign lane_mask = (width == `ISB_W_ONE) ? {{9{1'b1}}, 27'h0} :
                       (width == `ISB_W_TWO) ? {{18{1'b1}}, 18'h0} : {36{1'b1}};
    assign mod_loc = s_r.read_pointer - 3'd1;
    // Command chaining this cycle: every other buffer action yields to it
    assign chain = s_r.aw_got && s_r.w_got && !s_r.bvalid && s_r.awaddr == `ISB_OFF_CTRL;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        s_n = s_r;
        do_wr = 1'b0;
        do_rd = 1'b0;
        do_mod = 1'b0;
        rd_word = 36'h0;

        // Output-service phase sequence
        case (s_r.phase)
            PH_ONE:
            begin
                s_n.presence_generator = gen_pres(s_r.boff, s_r.wdata[2:0]);
                s_n.memory_request_latch = 1'b1;
                s_n.boff = s_r.boff + 2'($countones(gen_pres(s_r.boff, s_r.wdata[2:0])));
                s_n.phase = PH_TWO;
            end
            PH_TWO:
            begin
                s_n.saved_pres = s_r.presence_generator;
                s_n.phase = PH_FOUR;
            end
            PH_FOUR:
            begin
                // Stage cleared, then data and saved presence placed in it
                s_n.in_stage = {s_r.saved_pres[3], s_r.mem_asm[31:24],
                                s_r.saved_pres[2], s_r.mem_asm[23:16],
                                s_r.saved_pres[1], s_r.mem_asm[15:8],
                                s_r.saved_pres[0], s_r.mem_asm[7:0]};
                s_n.input_loaded_flag = 1'b1;
                s_n.memory_request_latch = 1'b0;
                s_n.phase = PH_IDLE;
            end
            default: s_n.phase = PH_IDLE;
        endcase

        // Buffer write side; a full buffer holds the stage until a read frees room
        if (s_r.fill_count != `ISB_FILL_FULL)
        begin
            if (s_r.mid_valid)
            begin
                // Intermediate stage goes to lanes A and B
                s_n.lanes[s_r.write_pointer] = {s_r.mid_stage, 18'h0};
                s_n.mid_valid = 1'b0;
                do_wr = 1'b1;
            end
            else if (s_r.input_loaded_flag && !(out_dir && narrow))
            begin
                s_n.lanes[s_r.write_pointer] = s_r.in_stage & lane_mask;
                s_n.input_loaded_flag = 1'b0;
                do_wr = 1'b1;
            end
        end

        // Commutation into the intermediate stage for narrow output
        if (!s_r.mid_valid && s_r.input_loaded_flag && out_dir && narrow)
        begin
            s_n.mid_valid = 1'b1;
            if (width == `ISB_W_TWO)
            begin
                // Pair A,B while either is present, otherwise pair C,D
                if (s_r.in_stage[35] || s_r.in_stage[26])
                begin
                    s_n.mid_stage = s_r.in_stage[35:18];
                    s_n.in_stage[35] = 1'b0;
                    s_n.in_stage[26] = 1'b0;
                end
                else
                begin
                    s_n.mid_stage = s_r.in_stage[17:0];
                    s_n.in_stage[17] = 1'b0;
                    s_n.in_stage[8] = 1'b0;
                end
            end
            else if (s_r.in_stage[35])
            begin
                s_n.mid_stage = {s_r.in_stage[35:27], 9'h0};
                s_n.in_stage[35] = 1'b0;
            end
            else if (s_r.in_stage[26])
            begin
                s_n.mid_stage = {s_r.in_stage[26:18], 9'h0};
                s_n.in_stage[26] = 1'b0;
            end
            else if (s_r.in_stage[17])
            begin
                s_n.mid_stage = {s_r.in_stage[17:9], 9'h0};
                s_n.in_stage[17] = 1'b0;
            end
            else
            begin
                s_n.mid_stage = {s_r.in_stage[8:0], 9'h0};
                s_n.in_stage[8] = 1'b0;
            end
            // Stage is spent once no presence bit is left
            if (pres_of(s_n.in_stage) == 4'h0)
                s_n.input_loaded_flag = 1'b0;
        end

        // AXI4-Lite write address and data, taken in either order
        if (s_req.awvalid && !s_r.aw_got && !s_r.bvalid)
        begin
            s_n.aw_got = 1'b1;
            s_n.awaddr = s_req.awaddr;
        end
        if (s_req.wvalid && !s_r.w_got && !s_r.bvalid)
        begin
            s_n.w_got = 1'b1;
            s_n.wdata = s_req.wdata;
        end
        if (s_r.bvalid && s_req.bready)
            s_n.bvalid = 1'b0;

        // Register write effects
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
        begin
            s_n.aw_got = 1'b0;
            s_n.w_got = 1'b0;
            s_n.bvalid = 1'b1;
            s_n.bresp = `ISB_RESP_OKAY;
            case (s_r.awaddr)
                `ISB_OFF_CTRL:
                begin
                    // Command chaining: pointers, count, input and intermediate stages start over
                    s_n.ctrl = s_r.wdata[4:0];
                    s_n.start_off = s_r.wdata[`ISB_CTRL_OFF];
                    s_n.boff = s_r.wdata[`ISB_CTRL_OFF];
                    s_n.write_pointer = `ISB_PTR_RST;
                    s_n.read_pointer = `ISB_PTR_RST;
                    s_n.fill_count = `ISB_FILL_EMPTY;
                    s_n.input_loaded_flag = 1'b0;
                    s_n.mid_valid = 1'b0;
                    s_n.memory_request_latch = 1'b0;
                    s_n.phase = PH_IDLE;
                    // A buffer write in the same cycle must not step the fresh pointers
                    do_wr = 1'b0;
                end
                `ISB_OFF_DIN:
                begin
                    // Device word loads only an idle stage, all bytes present
                    if (!out_dir && !s_r.input_loaded_flag)
                    begin
                        s_n.in_stage = {1'b1, s_r.wdata[31:24], 1'b1, s_r.wdata[23:16],
                                        1'b1, s_r.wdata[15:8], 1'b1, s_r.wdata[7:0]};
                        s_n.input_loaded_flag = 1'b1;
                    end
                    else if (out_dir)
                        s_n.mem_asm = s_r.wdata;
                end
                `ISB_OFF_SVC:
                begin
                    if (out_dir && s_r.phase == PH_IDLE && !s_r.input_loaded_flag)
                    begin
                        s_n.presence_generator = 4'h0;
                        s_n.phase = PH_ONE;
                    end
                end
                `ISB_OFF_DOUT:
                begin
                    if (s_r.fill_count != `ISB_FILL_EMPTY)
                    begin
                        do_rd = 1'b1;
                        rd_word = s_r.lanes[s_r.read_pointer];
                        if (!out_dir)
                        begin
                            // Word-aligned device data placed from the byte offset
                            s_n.out_stage = rotr(rd_word & lane_mask, s_r.boff);
                            s_n.boff = s_r.boff + 2'($countones(pres_of(rd_word & lane_mask)));
                        end
                        else if (narrow)
                            s_n.out_stage = rd_word;
                        else
                            s_n.out_stage = rotr(rd_word, 2'd0 - s_r.start_off);
                    end
                end
                `ISB_OFF_MODIFY:
                begin
                    // Location re-enters the buffer so the rest is read again
                    if (s_r.fill_count != `ISB_FILL_FULL && !do_wr)
                    begin
                        do_mod = 1'b1;
                        s_n.lanes[mod_loc] = s_r.lanes[mod_loc] &
                            ~{s_r.wdata[3], 8'h0, s_r.wdata[2], 8'h0,
                              s_r.wdata[1], 8'h0, s_r.wdata[0], 8'h0};
                    end
                end
                `ISB_OFF_STAT, `ISB_OFF_OPRES: s_n.bresp = `ISB_RESP_OKAY;
                default: s_n.bresp = `ISB_RESP_SLVERR;
            endcase
        end

        // Pointer, select and fill updates
        if (do_wr)
        begin
            s_n.write_pointer = s_r.write_pointer + 3'd1;
            s_n.location_select = s_r.write_pointer;
        end
        if (do_rd)
        begin
            s_n.read_pointer = s_r.read_pointer + 3'd1;
            s_n.location_select = s_r.read_pointer;
        end
        if (do_mod)
        begin
            s_n.read_pointer = mod_loc;
            s_n.location_select = mod_loc;
        end
        // Inverted count: a write counts down, a read counts up
        s_n.fill_count = s_n.fill_count - {3'h0, do_wr | do_mod} + {3'h0, do_rd};

        // AXI4-Lite read
        if (s_r.rvalid && s_req.rready)
            s_n.rvalid = 1'b0;
        if (s_req.arvalid && !s_r.rvalid)
        begin
            s_n.rvalid = 1'b1;
            s_n.rresp = `ISB_RESP_OKAY;
            case (s_req.araddr)
                `ISB_OFF_CTRL: s_n.rdata = {27'h0, s_r.ctrl};
                `ISB_OFF_STAT: s_n.rdata = {2'h0, s_r.mid_valid, s_r.boff,
                    s_r.presence_generator, s_r.saved_pres, pres_of(s_r.in_stage),
                    s_r.memory_request_latch, s_r.input_loaded_flag, s_r.fill_count,
                    s_r.location_select, s_r.read_pointer, s_r.write_pointer};
                `ISB_OFF_DOUT: s_n.rdata = {s_r.out_stage[34:27], s_r.out_stage[25:18],
                                            s_r.out_stage[16:9], s_r.out_stage[7:0]};
                `ISB_OFF_OPRES: s_n.rdata = {28'h0, pres_of(s_r.out_stage)};
                `ISB_OFF_DIN, `ISB_OFF_SVC, `ISB_OFF_MODIFY: s_n.rdata = 32'h0;
                default:
                begin
                    s_n.rdata = 32'h0;
                    s_n.rresp = `ISB_RESP_SLVERR;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r <= '0;
            s_r.ctrl <= `ISB_CTRL_RST;
            s_r.fill_count <= `ISB_FILL_EMPTY;
            s_r.phase <= PH_IDLE;
        end
        else
            s_r <= s_n;
    end

    // Handshakes combinational, answers registered
    assign s_rsp.awready = !s_r.aw_got && !s_r.bvalid;
    assign s_rsp.wready = !s_r.w_got && !s_r.bvalid;
    assign s_rsp.bvalid = s_r.bvalid;
    assign s_rsp.bresp = s_r.bresp;
    assign s_rsp.arready = !s_r.rvalid;
    assign s_rsp.rvalid = s_r.rvalid;
    assign s_rsp.rdata = s_r.rdata;
    assign s_rsp.rresp = s_r.rresp;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_chain_init;
        s_r.aw_got && s_r.w_got && !s_r.bvalid && s_r.awaddr == `ISB_OFF_CTRL
        |=> s_r.write_pointer == 3'h0 && s_r.read_pointer == 3'h0
            && s_r.fill_count == 4'hF;
    endproperty
    a_chain_init: assert property (p_chain_init) else $error("chain init wrong");

    property p_fill_range;
        s_r.fill_count[3] || s_r.fill_count == 4'h7;
    endproperty
    a_fill_range: assert property (p_fill_range) else $error("fill out of range");

    property p_no_write_full;
        s_r.write_pointer != $past(s_r.write_pointer) && !$past(chain)
        |-> $past(s_r.fill_count) != 4'h7;
    endproperty
    a_no_write_full: assert property (p_no_write_full) else $error("write when full");

    property p_wp_step;
        s_r.write_pointer != $past(s_r.write_pointer) && s_r.fill_count != 4'hF
        && s_r.read_pointer == $past(s_r.read_pointer)
        |-> s_r.write_pointer == $past(s_r.write_pointer) + 3'd1
            && s_r.location_select == $past(s_r.write_pointer);
    endproperty
    a_wp_step: assert property (p_wp_step) else $error("write pointer step");

    property p_fill_write;
        s_r.write_pointer == $past(s_r.write_pointer) + 3'd1
        && s_r.read_pointer == $past(s_r.read_pointer) && !$past(chain)
        |-> s_r.fill_count == $past(s_r.fill_count) - 4'd1;
    endproperty
    a_fill_write: assert property (p_fill_write) else $error("fill not decremented");

    property p_rp_step;
        s_r.read_pointer != $past(s_r.read_pointer) && s_r.read_pointer != 3'h0
        |-> s_r.read_pointer == $past(s_r.read_pointer) + 3'd1
            || s_r.read_pointer == $past(s_r.read_pointer) - 3'd1;
    endproperty
    a_rp_step: assert property (p_rp_step) else $error("read pointer step");

    property p_phase_seq;
        s_r.phase == PH_ONE |=> s_r.phase == PH_TWO && s_r.memory_request_latch
            ##1 s_r.phase == PH_FOUR ##1 s_r.input_loaded_flag;
    endproperty
    a_phase_seq: assert property (p_phase_seq) else $error("phase sequence");

    property p_saved;
        s_r.phase == PH_TWO |=> s_r.saved_pres == $past(s_r.presence_generator)
            ##1 pres_of(s_r.in_stage) == $past(s_r.saved_pres);
    endproperty
    a_saved: assert property (p_saved) else $error("saved presence");

    property p_one_lane_clear;
        s_r.mid_valid && !$past(s_r.mid_valid) && width == `ISB_W_ONE
        |-> $countones(pres_of(s_r.in_stage)) + 1
            == $countones(pres_of($past(s_r.in_stage)));
    endproperty
    a_one_lane_clear: assert property (p_one_lane_clear) else $error("presence clear");

    c_full: cover property (s_r.fill_count == 4'h7);
    c_phase_done: cover property (s_r.phase == PH_FOUR ##1 s_r.input_loaded_flag);
    c_modify: cover property (do_mod);
    c_narrow: cover property (s_r.mid_valid && width == `ISB_W_ONE);

endmodule : isb_buffer

// ### dv/isb_far_model.sv
/*
 Far-side word source standing in for core memory and the device.
 Assumes the bench picks the word by transfer number.
*/
`timescale 1ns/1ns
module isb_far_model (
    input wire logic [3:0] idx,
    output logic [31:0] word
);
    // Distinct bytes in every lane, so a lane swap cannot hide
    assign word = {4{4'h0, idx}} + 32'h1020_3040;
endmodule : isb_far_model

// ### dv/io_rate_smoothing_buffer_bench.sv
/*
 Bench of the rate-smoothing buffer: AXI4-Lite tasks, directed tests.
 Assumes isb_pkg and isb_consts.svh are compiled and on the path.
*/
`timescale 1ns/1ns
`include "isb_consts.svh"
module io_rate_smoothing_buffer_bench;
    import isb_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    isb_axi_req_t rq = '0;
    isb_axi_rsp_t rs;
    logic [3:0] idx = 4'h0;
    logic [31:0] word;
    logic [31:0] d;
    logic [1:0] rr;
    logic [1:0] br;
    int bad_count = 0;
    int checks = 0;

    // ----------------------------------------------------------------
    // Clock and parts
    // ----------------------------------------------------------------
    always #4 aclk = ~aclk;
    isb_buffer dut (.aclk(aclk), .aresetn(aresetn), .s_req(rq), .s_rsp(rs));
    isb_far_model far (.idx(idx), .word(word));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stall();
        bad_count++;
        $display("unexpected at %0t: no answer in time", $time);
        complete_run();
    endtask : stall

    // Handshakes are judged at the falling edge so the rising edge never races
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        logic ah;
        logic wh;
        logic bh;
        @(posedge aclk);
        rq <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:v, wstrb:4'hF,
                bready:1'b1, default:'0};
        for (int i = 0; i < 50; i++)
        begin
            @(negedge aclk);
            ah = rq.awvalid && rs.awready;
            wh = rq.wvalid && rs.wready;
            bh = rs.bvalid;
            br = bh ? rs.bresp : br;
            @(posedge aclk);
            if (ah) rq.awvalid <= 1'b0;
            if (wh) rq.wvalid <= 1'b0;
            if (bh)
            begin
                rq.bready <= 1'b0;
                return;
            end
        end
        stall();
    endtask : wr

    task automatic rd(input logic [4:0] a);
        logic ah;
        logic dh;
        @(posedge aclk);
        rq <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
        for (int i = 0; i < 50; i++)
        begin
            @(negedge aclk);
            ah = rq.arvalid && rs.arready;
            dh = rs.rvalid;
            d = dh ? rs.rdata : d;
            rr = dh ? rs.rresp : rr;
            @(posedge aclk);
            if (ah) rq.arvalid <= 1'b0;
            if (dh)
            begin
                rq.rready <= 1'b0;
                return;
            end
        end
        stall();
    endtask : rd

    task automatic chk_stat(input logic [2:0] wp, input logic [2:0] rp, input logic [3:0] f);
        rd(`ISB_OFF_STAT);
        chk({22'h0, d[12:9], d[5:0]}, {22'h0, f, rp, wp});
    endtask : chk_stat

    // Automatic buffer writes take a few cycles, so poll the fill count
    task automatic wait_fill(input logic [3:0] f);
        for (int i = 0; i < 20; i++)
        begin
            rd(`ISB_OFF_STAT);
            if (d[12:9] === f) return;
        end
        stall();
    endtask : wait_fill

    // The far-side word must settle on the new index before it is handed over
    task automatic feed(input logic [3:0] n);
        idx <= n;
        @(negedge aclk);
        wr(`ISB_OFF_DIN, word);
    endtask : feed

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk_stat(3'h0, 3'h0, `ISB_FILL_EMPTY);
        rd(5'h1C);
        chk({30'h0, rr}, {30'h0, `ISB_RESP_SLVERR});
        wr(5'h1C, 32'h0);
        chk({30'h0, br}, {30'h0, `ISB_RESP_SLVERR});
        $display("test reset done");
        // Nine words against eight places: the last waits in the input stage
        wr(`ISB_OFF_CTRL, 32'h0000_0003);
        for (int i = 0; i < 9; i++)
        begin
            feed(i[3:0]);
        end
        wait_fill(`ISB_FILL_FULL);
        chk_stat(3'h0, 3'h0, `ISB_FILL_FULL);
        chk({31'h0, d[13]}, 32'h1);
        for (int i = 0; i < 9; i++)
        begin
            idx <= i[3:0];
            wr(`ISB_OFF_DOUT, 32'h0);
            rd(`ISB_OFF_DOUT);
            chk(d, word);
            rd(`ISB_OFF_OPRES);
            chk({28'h0, d[3:0]}, 32'hF);
        end
        chk_stat(3'h1, 3'h1, `ISB_FILL_EMPTY);
        wr(`ISB_OFF_DOUT, 32'h0);
        chk_stat(3'h1, 3'h1, `ISB_FILL_EMPTY);
        wr(`ISB_OFF_MODIFY, 32'h0000_0008);
        chk_stat(3'h1, 3'h0, 4'hE);
        $display("test fill and drain done");
        // Input with start offset one: device word lands one lane late
        wr(`ISB_OFF_CTRL, 32'h0000_000B);
        chk_stat(3'h0, 3'h0, `ISB_FILL_EMPTY);
        feed(4'h5);
        wait_fill(4'hE);
        wr(`ISB_OFF_DOUT, 32'h0);
        rd(`ISB_OFF_DOUT);
        chk(d, {word[7:0], word[31:8]});
        $display("test offset done");
        // One-lane output, offset one, two bytes: B then C into lane A
        wr(`ISB_OFF_CTRL, 32'h0000_000C);
        feed(4'h6);
        wr(`ISB_OFF_SVC, 32'h0000_0002);
        wait_fill(4'hD);
        chk({28'h0, d[22:19]}, 32'h6);
        chk({30'h0, d[28:27]}, 32'h3);
        chk({31'h0, d[13]}, 32'h0);
        wr(`ISB_OFF_DOUT, 32'h0);
        rd(`ISB_OFF_DOUT);
        chk({24'h0, d[31:24]}, {24'h0, word[23:16]});
        wr(`ISB_OFF_DOUT, 32'h0);
        rd(`ISB_OFF_DOUT);
        chk({24'h0, d[31:24]}, {24'h0, word[15:8]});
        // Two-lane output, offset two: C and D go to lanes A and B at once
        wr(`ISB_OFF_CTRL, 32'h0000_0015);
        wr(`ISB_OFF_DIN, word);
        wr(`ISB_OFF_SVC, 32'h0000_0002);
        wait_fill(4'hE);
        wr(`ISB_OFF_DOUT, 32'h0);
        rd(`ISB_OFF_DOUT);
        chk({16'h0, d[31:16]}, {16'h0, word[15:0]});
        $display("test narrow output done");
        // Four-lane output, offset one, three bytes: the word leaves aligned to lane A
        wr(`ISB_OFF_CTRL, 32'h0000_000F);
        feed(4'h7);
        wr(`ISB_OFF_SVC, 32'h0000_0003);
        wait_fill(4'hE);
        wr(`ISB_OFF_DOUT, 32'h0);
        rd(`ISB_OFF_DOUT);
        chk(d, {word[23:0], word[31:24]});
        rd(`ISB_OFF_OPRES);
        chk({28'h0, d[3:0]}, 32'hE);
        $display("test wide output done");
        complete_run();
    end
endmodule : io_rate_smoothing_buffer_bench
